// file: include/ide_defines.svh
// Offsets, field positions, reset values and fixed codes of the IDE
// function configuration header. Included by its bare name.
`ifndef IDE_DEFINES_SVH
`define IDE_DEFINES_SVH

// Byte offsets in configuration space
`define IDE_OFS_STATUS 8'h06
`define IDE_OFS_REV 8'h08
`define IDE_OFS_CLASS 8'h09
`define IDE_OFS_LAT 8'h0D
`define IDE_OFS_HDR 8'h0E
`define IDE_OFS_BASE 8'h20

// Dword index of each offset
`define IDE_DW_STATUS 6'h01
`define IDE_DW_ID 6'h02
`define IDE_DW_MISC 6'h03
`define IDE_DW_BASE 6'h08

// Status layout; status sits in the upper half of its dword
`define IDE_STS_LSB 16
`define IDE_STS_INIT_ABORT 13
`define IDE_STS_GOT_ABORT 12
`define IDE_STS_SENT_ABORT 11
`define IDE_STS_RST 16'h0280
`define IDE_SEL_MEDIUM 2'h1

// Fixed codes and reset values
`define IDE_CLASS_CODE 24'h010180
`define IDE_HDR_TYPE 8'h00
`define IDE_LAT_RST 4'h0
`define IDE_BASE_RST 32'h00000001
`define IDE_BASE_IO 4'h1

// Bus-master window decode
`define IDE_CHAN_BYTES 4'h6
`define IDE_SEC_OFS 4'h8

`endif

// file: include/ide_pkg.sv
// Types shared by the IDE function configuration header.
// Numeric constants of the header are in ide_defines.svh; the state encodings here are literal.
`default_nettype none
package ide_pkg;

  typedef struct packed {
    logic valid;
    logic write;
    logic [5:0] idx;
    logic [3:0] be;
    logic [31:0] wdata;
  } ide_cfg_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } ide_cfg_rsp_s;

  typedef enum logic [2:0] {
    ide_lt_idle = 3'b001,
    ide_lt_count = 3'b010,
    ide_lt_expired = 3'b100
  } ide_lat_state_e;

endpackage
`default_nettype wire

// file: hdl/ide_cfg_header.sv
// IDE function configuration header: status flags, fixed identity,
// burst latency timer and bus-master I/O window base and decode.
// Assumes configuration cycles arrive as one-dword requests with byte
// enables, all inputs but arst_n synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "ide_defines.svh"

////////////////////////////////////////////////////////////////////////
// Sticky event flag, cleared by software

module ide_w1c_flag (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic set,
  input wire logic clr,
  output logic q
);
  // Set wins so an event in the clearing cycle is kept
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      q <= 1'b0;
    end else if (ce) begin
      if (set) begin
        q <= 1'b1;
      end else if (clr) begin
        q <= 1'b0;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////

module ide_cfg_header #(
  // Arbitrary neutral stepping value
  parameter logic [7:0] REVISION = 8'h3C
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic ce,
  input wire ide_pkg::ide_cfg_req_s cfg_req,
  output ide_pkg::ide_cfg_rsp_s cfg_rsp,
  input wire logic master_abort_evt,
  input wire logic target_abort_evt,
  input wire logic sent_abort_evt,
  input wire logic frame_driven,
  input wire logic hold_acknowledge_grant_n,
  output logic burst_stop,
  input wire logic io_valid,
  input wire logic [15:0] io_addr,
  output logic io_hit,
  output logic io_secondary
);
  import ide_pkg::*;

  logic take;
  logic wr;
  logic sts_wr;
  logic initiator_abort_flag;
  logic got_target_abort_flag;
  logic sent_target_abort_flag;
  logic [1:0] select_timing_field;
  logic back_to_back_capable;
  logic data_parity_flag;
  logic [15:0] function_status;
  logic [23:0] function_class;
  logic [3:0] latency_count_field;
  logic [7:0] burst_latency_timer;
  logic [7:0] lat_limit;
  logic [7:0] lat_cnt;
  logic [8:0] lat_cnt_inc;
  ide_lat_state_e lat_state;
  ide_lat_state_e next_lat_state;
  logic [11:0] base_addr;
  logic [31:0] bus_master_io_base;
  logic [31:0] next_rdata;
  logic [3:0] io_ofs;
  logic io_pri;
  logic io_sec;

  assign take = ce && cfg_req.valid;
  assign wr = take && cfg_req.write;

  //////////////////////////////////////////////////////////////////////
  // Status register

  assign sts_wr = wr && (cfg_req.idx == `IDE_DW_STATUS) && cfg_req.be[3];

  ide_w1c_flag u_init_abort (
    .clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .q(initiator_abort_flag),
    .set(master_abort_evt),
    .clr(sts_wr && cfg_req.wdata[`IDE_STS_LSB + `IDE_STS_INIT_ABORT])
  );

  ide_w1c_flag u_got_abort (
    .clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .q(got_target_abort_flag),
    .set(target_abort_evt),
    .clr(sts_wr && cfg_req.wdata[`IDE_STS_LSB + `IDE_STS_GOT_ABORT])
  );

  ide_w1c_flag u_sent_abort (
    .clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .q(sent_target_abort_flag),
    .set(sent_abort_evt),
    .clr(sts_wr && cfg_req.wdata[`IDE_STS_LSB + `IDE_STS_SENT_ABORT])
  );

  assign select_timing_field = `IDE_SEL_MEDIUM;
  assign back_to_back_capable = 1'b1;
  assign data_parity_flag = 1'b0;

  // Reserved low bits and unimplemented error bits stay zero
  assign function_status = {2'h0, initiator_abort_flag, got_target_abort_flag,
                            sent_target_abort_flag, select_timing_field, data_parity_flag,
                            back_to_back_capable, 7'h00};

  //////////////////////////////////////////////////////////////////////
  // Fixed identity

  assign function_class = `IDE_CLASS_CODE;

  //////////////////////////////////////////////////////////////////////
  // Burst latency timer

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      latency_count_field <= `IDE_LAT_RST;
    end else if (wr && (cfg_req.idx == `IDE_DW_MISC) && cfg_req.be[1]) begin
      latency_count_field <= cfg_req.wdata[15:12];
    end
  end

  assign burst_latency_timer = {latency_count_field, 4'h0};
  assign lat_limit = {latency_count_field, 4'h0};
  assign lat_cnt_inc = {1'b0, lat_cnt} + 9'h001;

  always_comb begin
    next_lat_state = lat_state;
    case (lat_state)
      ide_lt_idle: begin
        if (frame_driven) begin
          if (lat_limit == 8'h00) begin
            next_lat_state = ide_lt_expired;
          end else begin
            next_lat_state = ide_lt_count;
          end
        end
      end
      ide_lt_count: begin
        if (!frame_driven) begin
          next_lat_state = ide_lt_idle;
        end else if (lat_cnt_inc >= {1'b0, lat_limit}) begin
          next_lat_state = ide_lt_expired;
        end
      end
      ide_lt_expired: begin
        if (!frame_driven) begin
          next_lat_state = ide_lt_idle;
        end
      end
      default: begin
        next_lat_state = ide_lt_idle;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lat_state <= ide_lt_idle;
    end else if (ce) begin
      lat_state <= next_lat_state;
    end
  end

  // Counter stops once expired, so it never wraps past the limit
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lat_cnt <= 8'h00;
    end else if (ce) begin
      if (!frame_driven) begin
        lat_cnt <= 8'h00;
      end else if (lat_state != ide_lt_expired) begin
        lat_cnt <= lat_cnt_inc[7:0];
      end
    end
  end

  // Grant keeps the burst alive; once expired, the burst ends whenever grant is inactive
  assign burst_stop = (lat_state == ide_lt_expired) && frame_driven
                      && hold_acknowledge_grant_n;

  //////////////////////////////////////////////////////////////////////
  // Bus-master base address and window decode

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      base_addr <= 12'(`IDE_BASE_RST >> 4);
    end else if (wr && (cfg_req.idx == `IDE_DW_BASE)) begin
      if (cfg_req.be[0]) begin
        base_addr[3:0] <= cfg_req.wdata[7:4];
      end
      if (cfg_req.be[1]) begin
        base_addr[11:4] <= cfg_req.wdata[15:8];
      end
    end
  end

  assign bus_master_io_base = {16'h0000, base_addr, `IDE_BASE_IO};

  assign io_ofs = io_addr[3:0];
  assign io_pri = io_ofs < `IDE_CHAN_BYTES;
  assign io_sec = (io_ofs >= `IDE_SEC_OFS)
                  && (io_ofs < (`IDE_SEC_OFS + `IDE_CHAN_BYTES));

  // Registered to keep decode off the address path timing
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      io_hit <= 1'b0;
      io_secondary <= 1'b0;
    end else if (ce) begin
      io_hit <= io_valid && (io_addr[15:4] == base_addr)
                && (io_pri || io_sec);
      io_secondary <= io_sec;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Configuration read-back

  always_comb begin
    next_rdata = 32'h00000000;
    if (cfg_req.idx == `IDE_DW_STATUS) begin
      next_rdata = {function_status, 16'h0000};
    end else if (cfg_req.idx == `IDE_DW_ID) begin
      next_rdata = {function_class, REVISION};
    end else if (cfg_req.idx == `IDE_DW_MISC) begin
      next_rdata = {8'h00, `IDE_HDR_TYPE, burst_latency_timer, 8'h00};
    end else if (cfg_req.idx == `IDE_DW_BASE) begin
      next_rdata = bus_master_io_base;
    end
  end

  // Unmapped dwords read zero and writes to them are dropped
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cfg_rsp.ack <= 1'b0;
      cfg_rsp.rdata <= 32'h00000000;
    end else if (ce) begin
      cfg_rsp.ack <= cfg_req.valid;
      if (cfg_req.valid && !cfg_req.write) begin
        cfg_rsp.rdata <= next_rdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  sequence s_rd(logic [5:0] dw);
    ce && cfg_req.valid && !cfg_req.write && (cfg_req.idx == dw)
    ##1 ce && cfg_rsp.ack;
  endsequence

  // Clear with no competing event, since the event would win
  sequence s_clr(logic [31:0] mask, logic evt);
    sts_wr && ((cfg_req.wdata & mask) == mask) && !evt;
  endsequence

  a_init_abort_set:
    assert property (ce && master_abort_evt |=> initiator_abort_flag)
    else $error("master abort flag not set");
  a_got_abort_set:
    assert property (ce && target_abort_evt |=> function_status[12])
    else $error("received target abort flag not set");
  a_sent_abort_set:
    assert property (ce && sent_abort_evt |=> function_status[11])
    else $error("signalled target abort flag not set");
  a_init_abort_clear:
    assert property (s_clr(32'h20000000, master_abort_evt) |=> !initiator_abort_flag)
    else $error("master abort flag not cleared by one");
  a_sts_fixed_bits:
    assert property (function_status[15:14] == 2'h0 && !function_status[8])
    else $error("unimplemented status bits not zero");
  a_sts_read_fixed:
    assert property (s_rd(`IDE_DW_STATUS) |-> cfg_rsp.rdata[22:16] == 7'h00
                     && cfg_rsp.rdata[23] && cfg_rsp.rdata[26:25] == `IDE_SEL_MEDIUM)
    else $error("status fixed fields read wrong");
  a_sts_select_timing:
    assert property (function_status[10:7] == 4'h5)
    else $error("select timing or back-to-back bit wrong");
  a_b2b_one:
    assert property (back_to_back_capable)
    else $error("back-to-back capable bit low");
  a_id_read_fixed:
    assert property (s_rd(`IDE_DW_ID) |-> cfg_rsp.rdata == {24'h010180, REVISION})
    else $error("class or revision read wrong");
  a_rev_write_ignored:
    assert property (wr && cfg_req.idx == `IDE_DW_ID ##2 s_rd(`IDE_DW_ID)
                     |-> cfg_rsp.rdata[7:0] == REVISION)
    else $error("revision changed by write");
  a_w0_keeps_flag:
    assert property (sts_wr && !cfg_req.wdata[29] && initiator_abort_flag
                     |=> initiator_abort_flag)
    else $error("write of zero cleared a flag");
  a_lat_cleared:
    assert property (ce && !frame_driven |=> lat_cnt == 8'h00)
    else $error("latency counter not cleared off frame");
  a_lat_counts:
    assert property (ce && frame_driven && lat_state != ide_lt_expired
                     |=> lat_cnt == $past(lat_cnt) + 8'h01)
    else $error("latency counter did not count");
  a_lat_expires:
    assert property (ce && frame_driven && lat_state == ide_lt_count
                     && lat_cnt_inc == {1'b0, lat_limit} |=> lat_state == ide_lt_expired)
    else $error("latency count did not expire at limit");
  a_stop_on_release:
    assert property (frame_driven && hold_acknowledge_grant_n && lat_limit != 8'h00
                     && lat_cnt == lat_limit |-> burst_stop)
    else $error("no termination after grant removal");
  a_grant_holds_burst:
    assert property (!hold_acknowledge_grant_n |-> !burst_stop)
    else $error("burst stopped while grant active");
  a_hdr_read_zero:
    assert property (s_rd(`IDE_DW_MISC) |-> cfg_rsp.rdata[23:16] == 8'h00
                     && cfg_rsp.rdata[11:8] == 4'h0)
    else $error("header type or reserved latency bits not zero");
  a_base_fixed_bits:
    assert property (s_rd(`IDE_DW_BASE) |-> cfg_rsp.rdata[31:16] == 16'h0000
                     && cfg_rsp.rdata[3:0] == 4'h1)
    else $error("base hardwired bits wrong");
  a_base_write_back:
    assert property (wr && cfg_req.idx == `IDE_DW_BASE && cfg_req.be[1:0] == 2'h3
                     |=> base_addr == $past(cfg_req.wdata[15:4]))
    else $error("base address not stored");
  a_win_twelve_bytes:
    assert property (ce && io_valid && io_addr[15:4] == base_addr && io_addr[2:1] == 2'h3
                     |=> !io_hit)
    else $error("unused window byte decoded");

endmodule
`default_nettype wire

// file: dv/ide_host_model.sv
// Host side of the IDE function: configuration cycles and the grant.
// Assumes each request is answered at the edge taking it and read at the next falling edge.
`timescale 1ns/1ps
`default_nettype none

module ide_host_model (
  input wire logic clk_sys,
  input wire ide_pkg::ide_cfg_rsp_s cfg_rsp,
  output ide_pkg::ide_cfg_req_s cfg_req,
  output logic hold_acknowledge_grant_n
);
  import ide_pkg::*;

  logic [31:0] last_wdata;

  initial begin
    cfg_req = '0;
    last_wdata = 32'h00000000;
    hold_acknowledge_grant_n = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////

  // One request, held from a falling edge through the taking edge
  task automatic access(input logic wr, input logic [5:0] idx, input logic [3:0] be,
                        input logic [31:0] wd, output logic [31:0] rd,
                        output logic acked);
    @(negedge clk_sys);
    cfg_req.valid = 1'b1;
    cfg_req.write = wr;
    cfg_req.idx = idx;
    cfg_req.be = be;
    cfg_req.wdata = wd;
    last_wdata = wd;
    @(posedge clk_sys);
    @(negedge clk_sys);
    acked = cfg_rsp.ack;
    rd = cfg_rsp.rdata;
    cfg_req.valid = 1'b0;
    // Released bus must not keep showing the last data
    cfg_req.wdata = ~last_wdata;
  endtask

  // Called at a falling edge; grant is a level, active low
  function automatic void set_grant(input logic g_n);
    hold_acknowledge_grant_n = g_n;
  endfunction
endmodule

`default_nettype wire

// file: dv/ide_function_pci_config_header_tb_top.sv
// Self-checking bench of the IDE function configuration header.
// Assumes the host model for config cycles; inputs change at falling edges.
`timescale 1ns/1ps
`default_nettype none
`include "ide_defines.svh"

module ide_function_pci_config_header_tb_top;
  import ide_pkg::*;

  // Arbitrary stepping value
  localparam logic [7:0] REV = 8'h5A;
  logic clk_sys, arst_n, ce, frame_driven, grant_n, burst_stop;
  logic io_valid, io_hit, io_secondary, acked;
  logic [2:0] evt;
  logic [15:0] io_addr, exp_sts;
  logic [31:0] rd;
  ide_cfg_req_s cfg_req;
  ide_cfg_rsp_s cfg_rsp;
  int bad_count, n_checks, cycles;

  ide_cfg_header #(.REVISION(REV)) dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .cfg_req(cfg_req),
    .cfg_rsp(cfg_rsp), .master_abort_evt(evt[2]), .target_abort_evt(evt[1]),
    .sent_abort_evt(evt[0]), .frame_driven(frame_driven),
    .hold_acknowledge_grant_n(grant_n), .burst_stop(burst_stop),
    .io_valid(io_valid), .io_addr(io_addr), .io_hit(io_hit),
    .io_secondary(io_secondary)
  );

  ide_host_model host (
    .clk_sys(clk_sys), .cfg_rsp(cfg_rsp), .cfg_req(cfg_req),
    .hold_acknowledge_grant_n(grant_n)
  );

  ////////////////////////////////////////////////////////////////////////

  task automatic tally_and_finish();
    if (bad_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check32(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask

  task automatic check1(input string name, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %b seen %b", name, exp, got);
      bad_count++;
    end
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp, input string name);
    host.access(1'b0, idx, 4'hF, 32'h00000000, rd, acked);
    check1("ack", 1'b1, acked);
    check32(name, exp, rd);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [3:0] be, input logic [31:0] wd);
    host.access(1'b1, idx, be, wd, rd, acked);
    check1("ack", 1'b1, acked);
  endtask

  task automatic do_reset();
    arst_n = 1'b0;
    repeat (6) @(negedge clk_sys);
    arst_n = 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Whole run is under two hundred cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  initial begin
    arst_n = 1'b0;
    ce = 1'b1;
    evt = 3'b000;
    frame_driven = 1'b0;
    io_valid = 1'b0;
    io_addr = 16'h0000;
    do_reset();
    rd_chk(`IDE_DW_STATUS, {`IDE_STS_RST, 16'h0000}, "function_status");
    rd_chk(`IDE_DW_ID, {`IDE_CLASS_CODE, REV}, "class_revision");
    rd_chk(`IDE_DW_MISC, 32'h00000000, "header_latency");
    rd_chk(`IDE_DW_BASE, `IDE_BASE_RST, "bus_master_io_base");
    rd_chk(6'h3F, 32'h00000000, "unmapped");
    wr(`IDE_DW_STATUS, 4'hF, 32'hFFFFFFFF);
    rd_chk(`IDE_DW_STATUS, {`IDE_STS_RST, 16'h0000}, "function_status");
    wr(`IDE_DW_ID, 4'hF, 32'hFFFFFFFF);
    rd_chk(`IDE_DW_ID, {`IDE_CLASS_CODE, REV}, "class_revision");
    wr(`IDE_DW_MISC, 4'hF, 32'hFFFFFFFF);
    rd_chk(`IDE_DW_MISC, 32'h0000F000, "header_latency");
    wr(`IDE_DW_BASE, 4'hF, 32'hFFFFFFFF);
    rd_chk(`IDE_DW_BASE, 32'h0000FFF1, "bus_master_io_base");
    // Event flags: evt[0] sent abort, [1] received abort, [2] master abort
    for (int i = 0; i < 3; i++) begin
      @(negedge clk_sys);
      evt[i] = 1'b1;
      @(negedge clk_sys);
      evt = 3'b000;
      exp_sts = `IDE_STS_RST | (16'h0001 << (11 + i));
      rd_chk(`IDE_DW_STATUS, {exp_sts, 16'h0000}, "function_status");
      wr(`IDE_DW_STATUS, 4'b1000, 32'h00000000);
      rd_chk(`IDE_DW_STATUS, {exp_sts, 16'h0000}, "function_status");
      wr(`IDE_DW_STATUS, 4'b1000, 32'h00000001 << (27 + i));
      rd_chk(`IDE_DW_STATUS, {`IDE_STS_RST, 16'h0000}, "function_status");
    end
    // Clock enable low: no answer and no flag, whatever the inputs do
    @(negedge clk_sys);
    ce = 1'b0;
    evt = 3'b111;
    host.access(1'b0, `IDE_DW_STATUS, 4'hF, 32'h00000000, rd, acked);
    check1("ack", 1'b0, acked);
    evt = 3'b000;
    ce = 1'b1;
    rd_chk(`IDE_DW_STATUS, {`IDE_STS_RST, 16'h0000}, "function_status");
    // Latency field 1 gives a limit of 16 clocks
    wr(`IDE_DW_MISC, 4'b0010, 32'h00001000);
    @(negedge clk_sys);
    frame_driven = 1'b1;
    host.set_grant(1'b0);
    for (int k = 1; k <= 20; k++) begin
      @(negedge clk_sys);
      check1("burst_stop", 1'b0, burst_stop);
    end
    host.set_grant(1'b1);
    #1;
    check1("burst_stop", 1'b1, burst_stop);
    frame_driven = 1'b0;
    #1;
    check1("burst_stop", 1'b0, burst_stop);
    for (int pass = 0; pass < 2; pass++) begin
      @(negedge clk_sys);
      frame_driven = 1'b1;
      for (int k = 1; k <= 20; k++) begin
        @(negedge clk_sys);
        check1("burst_stop", k >= 16, burst_stop);
        if (pass == 1 && k == 10) begin
          frame_driven = 1'b0;
          #1;
          check1("burst_stop", 1'b0, burst_stop);
          break;
        end
      end
      frame_driven = 1'b0;
    end
    // Window at 1230h, then a miss above it and an unqualified address
    wr(`IDE_DW_BASE, 4'b0011, 32'h00001230);
    @(negedge clk_sys);
    for (int off = 0; off < 18; off++) begin
      io_valid = (off != 17);
      io_addr = 16'h1230 + 16'(off % 17);
      @(negedge clk_sys);
      check1("io_hit", off < 6 || (off >= 8 && off < 14), io_hit);
      if (io_hit === 1'b1) begin
        check1("io_secondary", off >= 8, io_secondary);
      end
    end
    io_valid = 1'b0;
    do_reset();
    rd_chk(`IDE_DW_BASE, `IDE_BASE_RST, "bus_master_io_base");
    rd_chk(`IDE_DW_MISC, 32'h00000000, "header_latency");
    tally_and_finish();
  end
endmodule

`default_nettype wire
